// >>> design/psd_window_cfg.svh
// Offsets, command bytes and timing counts of the register window block
`ifndef PSD_WINDOW_CFG_SVH
`define PSD_WINDOW_CFG_SVH

`define WINDOW_BYTES 256
`define OFS_A_LEVEL 8'h00
`define OFS_B_LEVEL 8'h01
`define OFS_A_FUNC 8'h02
`define OFS_B_FUNC 8'h03
`define OFS_A_DOUT 8'h04
`define OFS_B_DOUT 8'h05
`define OFS_A_DIR 8'h06
`define OFS_B_DIR 8'h07
`define OFS_A_DRV 8'h08
`define OFS_B_DRV 8'h09
`define OFS_A_IMC 8'h0A
`define OFS_B_IMC 8'h0B
`define OFS_A_OE 8'h0C
`define OFS_B_OE 8'h0D
`define OFS_C_LEVEL 8'h10
`define OFS_D_LEVEL 8'h11
`define OFS_C_DOUT 8'h12
`define OFS_D_DOUT 8'h13
`define OFS_C_DIR 8'h14
`define OFS_D_DIR 8'h15
`define OFS_C_DRV 8'h16
`define OFS_D_DRV 8'h17
`define OFS_C_IMC 8'h18
`define OFS_C_OE 8'h1A
`define OFS_D_OE 8'h1B
`define OFS_OMC_AB 8'h20
`define OFS_OMC_BC 8'h21
`define OFS_MASK_AB 8'h22
`define OFS_MASK_BC 8'h23
`define OFS_PWR_FIRST 8'hB0
`define OFS_PWR_THIRD 8'hB4
`define OFS_MAIN_LOCK 8'hC0
`define OFS_BOOT_LOCK 8'hC2
`define OFS_PAGE 8'hE0
`define OFS_PLACEMENT 8'hE2

// Placement register bit positions
`define VM_MAIN_DATA 0
`define VM_BOOT_DATA 1
`define VM_MAIN_PROG 2
`define VM_BOOT_PROG 3

// Flash command bytes and unlock addresses
`define UNLOCK_ADDR1 12'h555
`define UNLOCK_ADDR2 12'hAAA
`define UNLOCK_DATA1 8'hAA
`define UNLOCK_DATA2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_PROTECT_READ 8'h90
`define CMD_SECTOR_ERASE 8'h30
`define CMD_BULK_ERASE 8'h10
`define CMD_SUSPEND 8'hB0
`define CMD_RESET 8'hF0
`define PROTECT_STATUS_ADDR 2'h2

// Gap allowed between command bytes
`define CLK_MHZ 20
`define BYTE_TIMEOUT_US 80
`define TIMEOUT_CYCLES (`BYTE_TIMEOUT_US * `CLK_MHZ)
`define TMR_W 16
`define BUSY_W 24

`endif

// >>> design/psd_window_pkg.sv
// Types shared by the register window and sector decode
package psd_window_pkg;

  typedef logic [3:0][7:0] port_bytes_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic psen;
    logic ale;
  } mcu_bus_s;

  typedef struct packed {
    logic used;
    logic prog;
    logic [15:0] match;
    logic [15:0] care;
  } sel_term_s;

  typedef struct packed {
    logic prog;
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
    logic [11:0] sectors;
  } flash_op_s;

  typedef enum logic [3:0] {
    FL_READ, FL_UNLOCK1, FL_UNLOCK2, FL_PROG_DATA, FL_ERASE_SETUP,
    FL_ERASE_UNLOCK1, FL_ERASE_UNLOCK2, FL_ERASE_COLLECT,
    FL_PROGRAMMING, FL_ERASING, FL_SUSPENDED, FL_PROTECT_READ
  } flash_state_e;

  typedef struct packed {
    port_bytes_t sync1;
    port_bytes_t sync2;
    port_bytes_t sync3;
    port_bytes_t level;
    port_bytes_t dout;
    port_bytes_t dir;
    port_bytes_t drv;
    logic [7:0] func_a;
    logic [7:0] func_b;
    logic [7:0] omc_ab;
    logic [7:0] omc_bc;
    logic [7:0] mask_ab;
    logic [7:0] mask_bc;
    logic [7:0] pwr_first;
    logic [7:0] pwr_third;
    logic [7:0] page;
    logic [7:0] vm;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] rdata;
    logic rvalid;
    flash_state_e fst;
    logic [15:0] tmr;
    logic [23:0] busy_cnt;
    flash_op_s op;
  } psd_state_s;

endpackage : psd_window_pkg

// >>> design/sector_select_decode.sv
// Sector select decode built from up to three address terms per sector
`timescale 1ns/1ns
`default_nettype none

module sector_select_decode
#(
  parameter int SECTORS = 12,
  parameter int TERMS = 3
)
(
  input wire logic [15:0] addr_i,
  input wire logic prog_space_i,
  input wire logic data_space_i,
  input wire psd_window_pkg::sel_term_s [SECTORS-1:0][TERMS-1:0] terms_i,
  input wire logic [SECTORS-1:0] prog_allow_i,
  input wire logic [SECTORS-1:0] data_allow_i,
  output logic [SECTORS-1:0] sel_o
);
  import psd_window_pkg::*;

  function automatic logic term_hit(input sel_term_s t,
                                    input logic [15:0] a,
                                    input logic prog_ok,
                                    input logic data_ok);
    logic space_ok;
    space_ok = t.prog ? prog_ok : data_ok;
    return t.used && space_ok && (((a ^ t.match) & t.care) == 16'h0000);
  endfunction : term_hit

  always_comb
  begin
    for (int s = 0; s < SECTORS; s++)
    begin
      sel_o[s] = 1'b0;
      for (int t = 0; t < TERMS; t++)
      begin
        // Product terms OR together, each gated by memory placement
        sel_o[s] = sel_o[s] | term_hit(terms_i[s][t], addr_i,
          prog_space_i & prog_allow_i[s],
          data_space_i & data_allow_i[s]);
      end
    end
  end

endmodule : sector_select_decode

`default_nettype wire

// >>> design/psd_register_window.sv
// Register window, port pins and flash command control
// Behaviour
// - 256-byte register window at user base
// - level registers return synchronised pin levels
// - ports A/B select I/O or address out
// - output-data register drives output pins
// - direction register sets each pin's direction, except pin C3 while ready/busy is enabled
// - drive register: open-drain low, slew high
// - enable registers read pin driver enables
// - macrocell registers read outputs, writes load
// - mask register blocks macrocell loads
// - protection registers are read-only status
// - placement register maps memories into spaces
// - eight main, four boot sectors, lockable
// - sector erase, suspend and resume
// - sector selects from three address terms
// - ready/busy pin low while flash busy
// - flash reads like ROM, plain writes ignored
// - arrays programmed by the program command sequence
// - commands open with two unlock writes
// - bad byte or timeout returns to read
`timescale 1ns/1ns
`default_nettype none
`include "psd_window_cfg.svh"

module psd_register_window #(
  parameter int PROG_CYCLES = 400,
  parameter int ERASE_CYCLES = 20000
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire psd_window_pkg::mcu_bus_s bus_i,
  input wire logic [7:0] window_base_i,
  input wire psd_window_pkg::sel_term_s [11:0][2:0] sel_terms_i,
  input wire psd_window_pkg::port_bytes_t pin_level_i,
  input wire logic [23:0] input_cells_i,
  input wire logic [7:0] main_lock_i,
  input wire logic [3:0] boot_lock_i,
  input wire logic security_i,
  input wire logic ready_busy_enable_i,
  input wire logic [7:0] flash_rdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output psd_window_pkg::port_bytes_t pin_out_o,
  output psd_window_pkg::port_bytes_t pin_oe_n_o,
  output psd_window_pkg::port_bytes_t pin_fast_slew_o,
  output logic [15:0] logic_outputs_o,
  output logic [7:0] power_control_first_o,
  output logic [7:0] power_control_third_o,
  output logic [7:0] address_page_extension_o,
  output logic [11:0] sector_selects_o,
  output logic flash_busy_o,
  output psd_window_pkg::flash_op_s flash_op_o
);
  import psd_window_pkg::*;

  psd_state_s st;
  psd_state_s next_st;
  port_bytes_t drive_en;
  port_bytes_t pin_src;
  logic [11:0] sel;
  logic [11:0] lock;
  logic win_hit;
  logic win_rd;
  logic win_wr;
  logic fl_wr;
  logic fl_rd;
  logic [11:0] cmd_addr;
  logic [7:0] wd;
  logic hit_locked;
  logic is_unlock1;
  logic is_unlock2;
  logic busy;

  ////////////////////////////////////////////////////////////////////////
  // Decode of window and sector selects

  assign lock = {boot_lock_i, main_lock_i};
  assign win_hit = (bus_i.rd | bus_i.wr) &&
                   (bus_i.addr[15:8] == window_base_i);
  assign win_rd = win_hit & bus_i.rd;
  assign win_wr = win_hit & bus_i.wr;
  assign fl_wr = bus_i.wr & ~win_hit & (|sel);
  assign fl_rd = (bus_i.rd | bus_i.psen) & ~win_hit & (|sel);
  assign cmd_addr = bus_i.addr[11:0];
  assign wd = bus_i.wdata;
  assign hit_locked = |(sel & lock);
  assign is_unlock1 = (cmd_addr == `UNLOCK_ADDR1) &&
                      (wd == `UNLOCK_DATA1);
  assign is_unlock2 = (cmd_addr == `UNLOCK_ADDR2) &&
                      (wd == `UNLOCK_DATA2);
  assign busy = (st.fst == FL_PROGRAMMING) || (st.fst == FL_ERASING);

  sector_select_decode #(
    .SECTORS(12),
    .TERMS(3)
  ) u_sector_decode (
    .addr_i(bus_i.addr),
    .prog_space_i(bus_i.psen),
    .data_space_i(bus_i.rd | bus_i.wr),
    .terms_i(sel_terms_i),
    .prog_allow_i({{4{st.vm[`VM_BOOT_PROG]}}, {8{st.vm[`VM_MAIN_PROG]}}}),
    .data_allow_i({{4{st.vm[`VM_BOOT_DATA]}}, {8{st.vm[`VM_MAIN_DATA]}}}),
    .sel_o(sel)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        pin_src[p][b] = st.dout[p][b];
        if (p == 0 && st.func_a[b])
        begin
          pin_src[p][b] = st.addr_lo[b];
        end
        if (p == 1 && st.func_b[b])
        begin
          pin_src[p][b] = st.addr_hi[b];
        end
        drive_en[p][b] = st.dir[p][b];
        if (b < 4 && st.drv[p][b] && pin_src[p][b])
        begin
          drive_en[p][b] = 1'b0;
        end
        pin_fast_slew_o[p][b] = (b >= 4) && st.drv[p][b];
      end
    end
    if (ready_busy_enable_i)
    begin
      pin_src[2][3] = ~busy;
      drive_en[2][3] = 1'b1;
    end
  end

  assign pin_out_o = pin_src;
  assign pin_oe_n_o = ~drive_en;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.op.prog = 1'b0;
    next_st.op.erase = 1'b0;
    next_st.sync1 = pin_level_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.level = (st.sync2 & ~(st.sync2 ^ st.sync3)) |
                    (st.level & (st.sync2 ^ st.sync3));
    if (bus_i.ale)
    begin
      next_st.addr_lo = bus_i.addr[7:0];
      next_st.addr_hi = bus_i.addr[15:8];
    end
    if (win_wr)
    begin
      case (bus_i.addr[7:0])
        `OFS_A_FUNC: next_st.func_a = wd;
        `OFS_B_FUNC: next_st.func_b = wd;
        `OFS_A_DOUT: next_st.dout[0] = wd;
        `OFS_B_DOUT: next_st.dout[1] = wd;
        `OFS_C_DOUT: next_st.dout[2] = wd;
        `OFS_D_DOUT: next_st.dout[3] = wd;
        `OFS_A_DIR: next_st.dir[0] = wd;
        `OFS_B_DIR: next_st.dir[1] = wd;
        `OFS_C_DIR: next_st.dir[2] = wd;
        `OFS_D_DIR: next_st.dir[3] = wd;
        `OFS_A_DRV: next_st.drv[0] = wd;
        `OFS_B_DRV: next_st.drv[1] = wd;
        `OFS_C_DRV: next_st.drv[2] = wd;
        `OFS_D_DRV: next_st.drv[3] = wd;
        `OFS_OMC_AB: next_st.omc_ab = (st.omc_ab & st.mask_ab) |
                                      (wd & ~st.mask_ab);
        `OFS_OMC_BC: next_st.omc_bc = (st.omc_bc & st.mask_bc) |
                                      (wd & ~st.mask_bc);
        `OFS_MASK_AB: next_st.mask_ab = wd;
        `OFS_MASK_BC: next_st.mask_bc = wd;
        `OFS_PWR_FIRST: next_st.pwr_first = wd;
        `OFS_PWR_THIRD: next_st.pwr_third = wd;
        `OFS_PAGE: next_st.page = wd;
        `OFS_PLACEMENT: next_st.vm = wd;
        default: next_st.page = st.page;
      endcase
    end
    if (win_rd)
    begin
      next_st.rvalid = 1'b1;
      case (bus_i.addr[7:0])
        `OFS_A_LEVEL: next_st.rdata = st.level[0];
        `OFS_B_LEVEL: next_st.rdata = st.level[1];
        `OFS_C_LEVEL: next_st.rdata = st.level[2];
        `OFS_D_LEVEL: next_st.rdata = st.level[3];
        `OFS_A_FUNC: next_st.rdata = st.func_a;
        `OFS_B_FUNC: next_st.rdata = st.func_b;
        `OFS_A_DOUT: next_st.rdata = st.dout[0];
        `OFS_B_DOUT: next_st.rdata = st.dout[1];
        `OFS_C_DOUT: next_st.rdata = st.dout[2];
        `OFS_D_DOUT: next_st.rdata = st.dout[3];
        `OFS_A_DIR: next_st.rdata = st.dir[0];
        `OFS_B_DIR: next_st.rdata = st.dir[1];
        `OFS_C_DIR: next_st.rdata = st.dir[2];
        `OFS_D_DIR: next_st.rdata = st.dir[3];
        `OFS_A_DRV: next_st.rdata = st.drv[0];
        `OFS_B_DRV: next_st.rdata = st.drv[1];
        `OFS_C_DRV: next_st.rdata = st.drv[2];
        `OFS_D_DRV: next_st.rdata = st.drv[3];
        `OFS_A_IMC: next_st.rdata = input_cells_i[7:0];
        `OFS_B_IMC: next_st.rdata = input_cells_i[15:8];
        `OFS_C_IMC: next_st.rdata = input_cells_i[23:16];
        `OFS_A_OE: next_st.rdata = drive_en[0];
        `OFS_B_OE: next_st.rdata = drive_en[1];
        `OFS_C_OE: next_st.rdata = drive_en[2];
        `OFS_D_OE: next_st.rdata = drive_en[3];
        `OFS_OMC_AB: next_st.rdata = st.omc_ab;
        `OFS_OMC_BC: next_st.rdata = st.omc_bc;
        `OFS_MASK_AB: next_st.rdata = st.mask_ab;
        `OFS_MASK_BC: next_st.rdata = st.mask_bc;
        `OFS_PWR_FIRST: next_st.rdata = st.pwr_first;
        `OFS_PWR_THIRD: next_st.rdata = st.pwr_third;
        `OFS_MAIN_LOCK: next_st.rdata = main_lock_i;
        `OFS_BOOT_LOCK: next_st.rdata = {security_i, 3'h0,
                                         boot_lock_i};
        `OFS_PAGE: next_st.rdata = st.page;
        `OFS_PLACEMENT: next_st.rdata = st.vm;
        default: next_st.rdata = 8'h00;
      endcase
    end
    else if (fl_rd)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = flash_rdata_i;
      if (st.fst == FL_PROTECT_READ &&
          bus_i.addr[1:0] == `PROTECT_STATUS_ADDR)
      begin
        next_st.rdata = {7'h00, hit_locked};
      end
    end

    // Flash command sequencer; byte gap timer reloads on each flash write and counts down in every state
    if (st.tmr != 16'h0000)
    begin
      next_st.tmr = st.tmr - 16'h0001;
    end
    if (fl_wr)
    begin
      next_st.tmr = 16'(`TIMEOUT_CYCLES);
    end
    case (st.fst)
      FL_READ:
      begin
        if (fl_wr && is_unlock1)
        begin
          next_st.fst = FL_UNLOCK1;
        end
      end
      FL_UNLOCK1, FL_ERASE_UNLOCK1:
      begin
        if (fl_wr)
        begin
          next_st.fst = !is_unlock2 ? FL_READ :
            (st.fst == FL_UNLOCK1) ? FL_UNLOCK2 : FL_ERASE_UNLOCK2;
        end
        else if (st.tmr == 16'h0001)
        begin
          next_st.fst = FL_READ;
        end
      end
      FL_UNLOCK2, FL_ERASE_SETUP, FL_ERASE_UNLOCK2, FL_PROG_DATA:
      begin
        if (fl_wr)
        begin
          next_st.fst = FL_READ;
          if (st.fst == FL_PROG_DATA && !hit_locked)
          begin
            next_st.op.addr = bus_i.addr;
            next_st.op.data = wd;
            next_st.busy_cnt = `BUSY_W'(PROG_CYCLES);
            next_st.fst = FL_PROGRAMMING;
          end
          else if (st.fst == FL_ERASE_SETUP && is_unlock1)
          begin
            next_st.fst = FL_ERASE_UNLOCK1;
          end
          else if (st.fst == FL_UNLOCK2 && cmd_addr == `UNLOCK_ADDR1)
          begin
            case (wd)
              `CMD_PROGRAM: next_st.fst = FL_PROG_DATA;
              `CMD_ERASE_SETUP: next_st.fst = FL_ERASE_SETUP;
              `CMD_PROTECT_READ: next_st.fst = FL_PROTECT_READ;
              default: next_st.fst = FL_READ;
            endcase
          end
          else if (st.fst == FL_ERASE_UNLOCK2)
          begin
            if (wd == `CMD_SECTOR_ERASE)
            begin
              next_st.op.sectors = sel & ~lock;
              next_st.fst = FL_ERASE_COLLECT;
            end
            else if (wd == `CMD_BULK_ERASE && cmd_addr == `UNLOCK_ADDR1)
            begin
              next_st.op.sectors = (|sel[7:0]) ? {4'h0, ~main_lock_i} :
                                                {~boot_lock_i, 8'h00};
              next_st.busy_cnt = `BUSY_W'(ERASE_CYCLES);
              next_st.fst = FL_ERASING;
            end
          end
        end
        else if (st.tmr == 16'h0001)
        begin
          next_st.fst = FL_READ;
        end
      end
      FL_ERASE_COLLECT:
      begin
        if (fl_wr && wd == `CMD_SECTOR_ERASE)
        begin
          next_st.op.sectors = st.op.sectors | (sel & ~lock);
        end
        else if (fl_wr)
        begin
          next_st.fst = FL_READ;
        end
        else if (st.tmr == 16'h0001)
        begin
          next_st.busy_cnt = `BUSY_W'(ERASE_CYCLES);
          next_st.fst = (st.op.sectors == 12'h000) ? FL_READ : FL_ERASING;
        end
      end
      FL_PROGRAMMING, FL_ERASING:
      begin
        next_st.busy_cnt = st.busy_cnt - `BUSY_W'(1);
        if (st.fst == FL_ERASING && fl_wr && wd == `CMD_SUSPEND)
        begin
          next_st.busy_cnt = st.busy_cnt;
          next_st.fst = FL_SUSPENDED;
        end
        else if (st.busy_cnt <= `BUSY_W'(1))
        begin
          next_st.op.prog = (st.fst == FL_PROGRAMMING);
          next_st.op.erase = (st.fst == FL_ERASING);
          next_st.fst = FL_READ;
        end
      end
      FL_SUSPENDED:
      begin
        if (fl_wr && wd == `CMD_SECTOR_ERASE)
        begin
          next_st.fst = FL_ERASING;
        end
      end
      FL_PROTECT_READ:
      begin
        if (fl_wr && wd == `CMD_RESET)
        begin
          next_st.fst = FL_READ;
        end
      end
      default: next_st.fst = FL_READ;
    endcase
    if (fl_wr && wd == `CMD_RESET && !busy && st.fst != FL_SUSPENDED)
    begin
      next_st.fst = FL_READ;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign logic_outputs_o = {st.omc_bc, st.omc_ab};
  assign power_control_first_o = st.pwr_first;
  assign power_control_third_o = st.pwr_third;
  assign address_page_extension_o = st.page;
  assign sector_selects_o = sel;
  assign flash_busy_o = busy;
  assign flash_op_o = st.op;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_unmapped_read_zero: assert property (
    win_rd && (bus_i.addr[7:0] == 8'h30 || bus_i.addr[7:0] == 8'hFF)
    |=> rvalid_o && rdata_o == 8'h00)
    else $error("unmapped offset did not read zero");

  a_level_read_back: assert property (
    win_rd && bus_i.addr[7:0] == `OFS_A_LEVEL
    |=> rdata_o == $past(st.level[0]))
    else $error("port A level read wrong");

  a_address_out_mode: assert property (
    st.func_a[0] |-> pin_out_o[0][0] == st.addr_lo[0])
    else $error("address out mode not driving latched address");

  a_input_pin_released: assert property (
    !st.dir[1][2] && !(ready_busy_enable_i) |-> pin_oe_n_o[1][2])
    else $error("input pin is driven");

  a_enable_read_back: assert property (
    win_rd && bus_i.addr[7:0] == `OFS_C_OE
    |=> rdata_o == ~$past(pin_oe_n_o[2]))
    else $error("enable status read wrong");

  a_mask_holds_cells: assert property (
    win_wr && bus_i.addr[7:0] == `OFS_OMC_AB && st.mask_ab == 8'hFF
    |=> $stable(logic_outputs_o[7:0]))
    else $error("masked macrocells changed");

  a_lock_read_only: assert property (
    win_rd && bus_i.addr[7:0] == `OFS_MAIN_LOCK
    |=> rdata_o == $past(main_lock_i))
    else $error("protection status read wrong");

  a_ready_busy_low: assert property (
    ready_busy_enable_i && busy |-> !pin_out_o[2][3] && !pin_oe_n_o[2][3])
    else $error("ready/busy not low while busy");

  a_plain_write_ignored: assert property (
    st.fst == FL_READ && fl_wr && wd != `UNLOCK_DATA1
    |=> st.fst == FL_READ && !flash_op_o.prog)
    else $error("plain write altered flash state");

  a_gap_timeout: assert property (
    (st.fst == FL_UNLOCK1 || st.fst == FL_UNLOCK2) &&
    st.tmr == 16'h0001 && !fl_wr
    |=> st.fst == FL_READ)
    else $error("command gap timeout missed");

  a_program_done: assert property (
    st.fst == FL_PROGRAMMING && st.busy_cnt == `BUSY_W'(1) && !fl_wr
    |=> flash_op_o.prog ##1 !flash_op_o.prog)
    else $error("program pulse not one cycle at end");

endmodule : psd_register_window

`default_nettype wire

// >>> verif/mcu_bus_model.sv
// Processor core model issuing byte accesses on the internal bus
`timescale 1ns/1ns
`default_nettype none

module mcu_bus_model
(
  input wire logic clock_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  input wire logic busy_i,
  output var psd_window_pkg::mcu_bus_s bus_o
);
  import psd_window_pkg::*;

  initial bus_o = '0;

  ////////////////////////////////////////
  // One write strobe, data inverted once released
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_o.addr <= a;
    bus_o.wdata <= d;
    bus_o.wr <= 1'b1;
    bus_o.ale <= 1'b1;
    @(posedge clock_i);
    bus_o.wr <= 1'b0;
    bus_o.ale <= 1'b0;
    bus_o.wdata <= ~d;
  endtask : wr

  // Read strobe, data taken when valid shows
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    @(posedge clock_i);
    bus_o.addr <= a;
    bus_o.rd <= 1'b1;
    bus_o.ale <= 1'b1;
    @(posedge clock_i);
    bus_o.rd <= 1'b0;
    bus_o.ale <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (rvalid_i !== 1'b1 && n < 4);
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask : rd

  // Unlock pair, then command byte
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    wr({a[15:12], 12'h555}, 8'hAA);
    wr({a[15:12], 12'hAAA}, 8'h55);
    wr(a, c);
  endtask : cmd

  // Bounded wait on the flash busy level
  task automatic poll(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && busy_i !== lvl; n++)
      @(posedge clock_i);
  endtask : poll
endmodule : mcu_bus_model
`default_nettype wire

// >>> verif/test_psd_register_window.sv
// Self-checking bench of the register window and flash control
`timescale 1ns/1ns
`default_nettype none

module test_psd_register_window;
  import psd_window_pkg::*;
  logic clk, rst, sec, rbe, rvalid, busy;
  logic [7:0] base, mlock, frd, rdata, got, page, pw1, pw3;
  logic [11:0] ssel, last_sel = 12'h000;
  logic [3:0] block;
  logic [23:0] cells;
  logic [15:0] lout;
  mcu_bus_s bus;
  sel_term_s [11:0][2:0] terms;
  port_bytes_t lvl, pout, poe, pslew;
  flash_op_s op;
  int failures, tests_run, progs, erases;
  logic [23:0] rows [19] = '{
    24'h06F0F0, 24'h0C00F0, 24'h04A5A5,
    24'h020F0F, 24'h08F3F3, 24'h00FF3C,
    24'h0AFF96, 24'h1A0000, 24'h145555, 24'h205A5A, 24'h21C3C3,
    24'hB01111, 24'hB42222, 24'hE07E7E, 24'hE20303,
    24'hC0FF82, 24'hC2FF85,
    24'h30FF00, 24'hFF7700
  };

  psd_register_window #(.PROG_CYCLES(5), .ERASE_CYCLES(20)) u_dut (
    .clock_i(clk),
    .sys_rst_i(rst),
    .bus_i(bus),
    .window_base_i(base),
    .sel_terms_i(terms),
    .pin_level_i(lvl),
    .input_cells_i(cells),
    .main_lock_i(mlock),
    .boot_lock_i(block),
    .security_i(sec),
    .ready_busy_enable_i(rbe),
    .flash_rdata_i(frd),
    .rdata_o(rdata),
    .rvalid_o(rvalid),
    .pin_out_o(pout),
    .pin_oe_n_o(poe),
    .pin_fast_slew_o(pslew),
    .logic_outputs_o(lout),
    .power_control_first_o(pw1),
    .power_control_third_o(pw3),
    .address_page_extension_o(page),
    .sector_selects_o(ssel),
    .flash_busy_o(busy),
    .flash_op_o(op)
  );

  mcu_bus_model u_mcu (
    .clock_i(clk),
    .rvalid_i(rvalid),
    .rdata_i(rdata),
    .busy_i(busy),
    .bus_o(bus)
  );

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  always @(posedge clk)
  begin
    if (op.prog === 1'b1)
      progs++;
    if (op.erase === 1'b1)
      erases++;
    if (|ssel)
      last_sel <= ssel;
  end

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #2000000;
    failures++;
    finish_test();
  end

  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    base = 8'h40;
    sec = 1'b1;
    rbe = 1'b0;
    mlock = 8'h82;
    block = 4'h5;
    frd = 8'h6D;
    cells = 24'h000096;
    lvl = 32'h0000003C;
    terms = '0;
    terms[0][0] = '{1'b1, 1'b0, 16'h0000, 16'hF000};
    terms[8][0] = '{1'b1, 1'b0, 16'h8000, 16'hF000};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(poe, 32'hFFFFFFFF);
    check({rvalid, busy, rdata}, 0);
    foreach (rows[i])
    begin
      u_mcu.wr({base, rows[i][23:16]}, rows[i][15:8]);
      u_mcu.rd({base, rows[i][23:16]}, got);
      check(got, rows[i][7:0]);
    end
    check({poe[0][7:4], pout[0][7:4], pslew[0][7:4]}, 12'h0AF);
    check(page, 8'h7E);
    check({pw1, pw3}, 16'h1122);
    check(pout[0][3:0], 4'hF);
    u_mcu.wr({base, 8'h22}, 8'hFF);
    u_mcu.wr({base, 8'h20}, 8'h00);
    u_mcu.rd({base, 8'h20}, got);
    check(got, 8'h5A);
    check(lout, 16'hC35A);
    // Plain write, bad byte, gap and lock must all leave flash alone
    u_mcu.wr(16'h0100, 8'h12);
    u_mcu.rd(16'h0100, got);
    check({busy, got}, 9'h06D);
    u_mcu.cmd(16'h0555, 8'h77);
    u_mcu.wr(16'h0555, 8'hA0);
    u_mcu.wr(16'h0100, 8'h12);
    u_mcu.wr(16'h0555, 8'hAA);
    u_mcu.wr(16'h0AAA, 8'h55);
    repeat (1700) @(posedge clk);
    u_mcu.wr(16'h0555, 8'hA0);
    u_mcu.wr(16'h0100, 8'h12);
    rbe <= 1'b1;
    u_mcu.cmd(16'h8555, 8'hA0);
    u_mcu.wr(16'h8010, 8'h12);
    repeat (3) @(negedge clk);
    check({busy, progs[3:0]}, 0);
    check(last_sel, 12'h100);
    u_mcu.cmd(16'h8555, 8'h90);
    u_mcu.rd(16'h8002, got);
    check(got, 8'h01);
    u_mcu.wr(16'h8000, 8'hF0);
    u_mcu.rd(16'h8002, got);
    check(got, 8'h6D);
    u_mcu.cmd(16'h0555, 8'hA0);
    u_mcu.wr(16'h0234, 8'h5B);
    u_mcu.poll(1'b1, 4);
    @(negedge clk);
    check({busy, poe[2][3], pout[2][3]}, 3'b100);
    u_mcu.rd(16'h8010, got);
    check({busy, got}, 9'h16D);
    u_mcu.poll(1'b0, 20);
    @(negedge clk);
    check({pout[2][3], progs[3:0]}, 5'h11);
    check({op.addr, op.data}, 24'h02345B);
    // Sector erase with one suspend and resume
    u_mcu.cmd(16'h0555, 8'h80);
    u_mcu.cmd(16'h0000, 8'h30);
    u_mcu.poll(1'b1, 1700);
    u_mcu.wr(16'h0000, 8'hB0);
    @(negedge clk);
    check({busy, erases[3:0]}, 0);
    u_mcu.wr(16'h0000, 8'h30);
    u_mcu.poll(1'b1, 4);
    u_mcu.poll(1'b0, 40);
    @(negedge clk);
    check({erases[3:0], op.sectors}, 16'h1001);
    u_mcu.cmd(16'h8555, 8'h80);
    u_mcu.cmd(16'h8555, 8'h10);
    u_mcu.poll(1'b1, 4);
    u_mcu.poll(1'b0, 40);
    @(negedge clk);
    check({erases[3:0], op.sectors}, 16'h2A00);
    // Reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    u_mcu.rd({base, 8'h06}, got);
    check({got, lout, poe[2][3], pout[2][3]}, 26'h0000001);
    finish_test();
  end
endmodule : test_psd_register_window
`default_nettype wire
